// >>> hw/crb_rx_buffer_manager.sv
// Receive buffer and FIFO manager with its APB register file.
`timescale 1ns/1ps
`default_nettype none

`include "crb_consts.svh"

module crb_rx_buffer_manager
  import crb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] filter_hit,
  input wire logic [63:0] filter_buffer_pointer,
  input wire logic [7:0] tx_rx_select_bit,
  output logic dma_req,
  output logic [4:0] dma_buffer_index,
  output logic rx_buffer_irq_flag,
  output logic rx_overflow_irq_flag,
  output logic fifo_almost_full_irq
);

  crb_mgr_s s;
  crb_mgr_s next_s;
  crb_hit_if hif();

  function automatic logic [4:0] fifo_end(input logic [2:0] code);
    unique case (code)
      3'h0: fifo_end = 5'h03;
      3'h1: fifo_end = 5'h05;
      3'h2: fifo_end = 5'h07;
      3'h3: fifo_end = 5'h0b;
      3'h4: fifo_end = 5'h0f;
      3'h5: fifo_end = 5'h17;
      default: fifo_end = 5'h1f;
    endcase
  endfunction

  // Returns the software clear mask of one 16-bit flag half: bits written 0 that are set.
  function automatic logic [15:0] clear_mask(input logic [15:0] flags, input logic [15:0] wdata);
    clear_mask = flags & ~wdata;
  endfunction

  assign hif.hit = filter_hit;
  assign hif.bp_table = filter_buffer_pointer;
  assign hif.full = s.full;
  assign hif.tx_sel = tx_rx_select_bit;
  assign hif.wp = s.wp;

  crb_hit_select u_select (
    .mclk(mclk),
    .reset(reset),
    .hif(hif.selector)
  );

  always_comb begin
    logic setup;
    logic wr;
    logic [31:0] full_clr;
    logic [31:0] ovf_clr;
    logic [31:0] full_set;
    logic [31:0] ovf_set;
    logic [4:0] end_buf;
    logic [5:0] wp_new;
    logic [5:0] nr_cleared;
    logic any_cleared;
    logic cfg_wr;
    logic [4:0] cfg_start;
    setup = psel && !penable;
    wr = psel && penable && s.pready && pwrite;
    full_clr = 32'h0000_0000;
    ovf_clr = 32'h0000_0000;
    full_set = 32'h0000_0000;
    ovf_set = 32'h0000_0000;
    end_buf = fifo_end(s.count_sel);
    wp_new = s.wp;
    nr_cleared = s.nr;
    any_cleared = 1'b0;
    cfg_wr = 1'b0;
    cfg_start = pwdata[`CRB_FCTRL_START_MSB:`CRB_FCTRL_START_LSB];
    next_s = s;
    next_s.dma_req = 1'b0;
    next_s.rb_irq = 1'b0;
    next_s.ovf_irq = 1'b0;
    next_s.af_irq = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    // The answer is prepared in the setup cycle so that every bus output leaves a flop.
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        `CRB_OFF_FULL_LO: next_s.prdata[15:0] = s.full[15:0];
        `CRB_OFF_FULL_HI: next_s.prdata[15:0] = s.full[31:16];
        `CRB_OFF_OVF_LO: next_s.prdata[15:0] = s.ovf[15:0];
        `CRB_OFF_OVF_HI: next_s.prdata[15:0] = s.ovf[31:16];
        `CRB_OFF_FCTRL: begin
          next_s.prdata[`CRB_FCTRL_CNT_MSB:`CRB_FCTRL_CNT_LSB] = s.count_sel;
          next_s.prdata[`CRB_FCTRL_START_MSB:`CRB_FCTRL_START_LSB] = s.start;
        end
        `CRB_OFF_FPTR: begin
          next_s.prdata[`CRB_FPTR_WP_MSB:`CRB_FPTR_WP_LSB] = s.wp;
          next_s.prdata[`CRB_FPTR_NR_MSB:`CRB_FPTR_NR_LSB] = s.nr;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end

    if (wr) begin
      unique case (paddr)
        `CRB_OFF_FULL_LO: full_clr[15:0] = clear_mask(s.full[15:0], pwdata[15:0]);
        `CRB_OFF_FULL_HI: full_clr[31:16] = clear_mask(s.full[31:16], pwdata[15:0]);
        `CRB_OFF_OVF_LO: ovf_clr[15:0] = clear_mask(s.ovf[15:0], pwdata[15:0]);
        `CRB_OFF_OVF_HI: ovf_clr[31:16] = clear_mask(s.ovf[31:16], pwdata[15:0]);
        `CRB_OFF_FCTRL: cfg_wr = 1'b1;
        // Writes to fifo_pointers and unmapped words change nothing.
        default: cfg_wr = 1'b0;
      endcase
    end

    // next-read from clear
    // When several flags are cleared by one write the highest buffer number is taken.
    for (int i = 0; i < 32; i++) begin
      if (full_clr[i]) begin
        any_cleared = 1'b1;
        nr_cleared = 6'(i + 1);
      end
    end
    if (any_cleared) begin
      next_s.nr = nr_cleared;
    end

    if (hif.sel.valid) begin
      if (hif.sel.store) begin
        next_s.dma_req = 1'b1;
        next_s.dma_idx = hif.sel.index;
        full_set[hif.sel.index] = 1'b1;
        next_s.rb_irq = 1'b1;
      end else begin
        ovf_set[hif.sel.index] = 1'b1;
        next_s.ovf_irq = 1'b1;
      end
      if (hif.sel.fifo) begin
        // advance and wrap
        // A pointer left beyond the end by a narrowed count also wraps to the start.
        if (s.wp[4:0] >= end_buf) begin
          wp_new = {1'b0, s.start};
        end else begin
          wp_new = s.wp + 6'h01;
        end
        next_s.wp = wp_new;
        if (hif.sel.store) begin
          next_s.af_irq = ((next_s.nr - wp_new) == 6'h01) ||
                          ((next_s.nr == {1'b0, s.start}) && (wp_new == {1'b0, end_buf}));
        end
      end
    end

    next_s.full = (s.full & ~full_clr) | full_set;
    next_s.ovf = (s.ovf & ~ovf_clr) | ovf_set;

    if (cfg_wr) begin
      next_s.count_sel = pwdata[`CRB_FCTRL_CNT_MSB:`CRB_FCTRL_CNT_LSB];
      next_s.start = cfg_start;
      next_s.wp = {1'b0, cfg_start};
      next_s.nr = {1'b0, cfg_start};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
      s.count_sel <= `CRB_RST_CNT;
      s.start <= `CRB_RST_START;
      s.wp <= {1'b0, `CRB_RST_START};
      s.nr <= {1'b0, `CRB_RST_START};
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign dma_req = s.dma_req;
  assign dma_buffer_index = s.dma_idx;
  assign rx_buffer_irq_flag = s.rb_irq;
  assign rx_overflow_irq_flag = s.ovf_irq;
  assign fifo_almost_full_irq = s.af_irq;

endmodule

`default_nettype wire

// >>> hw/crb_consts.svh
// Register offsets, field positions, reset values and codes of the receive buffer manager.
`ifndef CRB_CONSTS_SVH
`define CRB_CONSTS_SVH

// Byte offsets on the register bus.
`define CRB_OFF_FULL_LO 12'h000
`define CRB_OFF_FULL_HI 12'h004
`define CRB_OFF_OVF_LO 12'h008
`define CRB_OFF_OVF_HI 12'h00c
`define CRB_OFF_FCTRL 12'h010
`define CRB_OFF_FPTR 12'h014

// Fields of fifo_control.
`define CRB_FCTRL_CNT_MSB 15
`define CRB_FCTRL_CNT_LSB 13
`define CRB_FCTRL_START_MSB 4
`define CRB_FCTRL_START_LSB 0

// Fields of fifo_pointers.
`define CRB_FPTR_WP_MSB 13
`define CRB_FPTR_WP_LSB 8
`define CRB_FPTR_NR_MSB 5
`define CRB_FPTR_NR_LSB 0

// Reset values.
`define CRB_RST_CNT 3'h0
`define CRB_RST_START 5'h00

// Filter pointer code that sends a message to the FIFO.
`define CRB_BP_FIFO 4'hf

// Buffers below this index have a transmit/receive select bit.
`define CRB_TX_CAPABLE 5'h08

`endif

// >>> hw/crb_pkg.sv
// Types shared by the receive buffer manager modules.
package crb_pkg;

  // Decision taken for one filter hit.
  typedef struct packed {
    logic valid;
    logic store;
    logic fifo;
    logic [4:0] index;
  } crb_sel_s;

  // Whole state of the manager.
  typedef struct packed {
    logic [31:0] full;
    logic [31:0] ovf;
    logic [2:0] count_sel;
    logic [4:0] start;
    logic [5:0] wp;
    logic [5:0] nr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic dma_req;
    logic [4:0] dma_idx;
    logic rb_irq;
    logic ovf_irq;
    logic af_irq;
  } crb_mgr_s;

endpackage

// >>> hw/crb_hit_if.sv
// Carrier between the manager and its hit selector.
`timescale 1ns/1ps
`default_nettype none

interface crb_hit_if;
  import crb_pkg::*;

  logic [15:0] hit;
  logic [63:0] bp_table;
  logic [31:0] full;
  logic [7:0] tx_sel;
  logic [5:0] wp;
  crb_sel_s sel;

  modport selector (input hit, input bp_table, input full, input tx_sel, input wp, output sel);
  modport manager (output hit, output bp_table, output full, output tx_sel, output wp, input sel);
endinterface

`default_nettype wire

// >>> hw/crb_hit_select.sv
// Resolves the filter hits of one message into a single buffer and a store or overflow decision.
`timescale 1ns/1ps
`default_nettype none

module crb_hit_select
  import crb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  crb_hit_if.selector hif
);

  crb_sel_s s;
  crb_sel_s next_s;

  // Maps a filter pointer code to the buffer it addresses.
  function automatic logic [4:0] hit_target(input logic [3:0] bp, input logic [5:0] wp);
    hit_target = (bp == `CRB_BP_FIFO) ? wp[4:0] : {1'b0, bp};
  endfunction

  always_comb begin
    logic [3:0] bp;
    logic [4:0] tgt;
    logic avail;
    logic any_hit;
    logic any_avail;
    logic [4:0] first_idx;
    logic first_fifo;
    logic [4:0] avail_idx;
    logic avail_fifo;
    bp = 4'h0;
    tgt = 5'h00;
    avail = 1'b0;
    any_hit = 1'b0;
    any_avail = 1'b0;
    first_idx = 5'h00;
    first_fifo = 1'b0;
    avail_idx = 5'h00;
    avail_fifo = 1'b0;
    // lowest filter with a free target wins
    // Walking downward lets the lowest-numbered filter overwrite the others.
    for (int i = 15; i >= 0; i--) begin
      if (hif.hit[i]) begin
        bp = hif.bp_table[i*4 +: 4];
        tgt = hit_target(bp, hif.wp);
        avail = !hif.full[tgt] && !((tgt < `CRB_TX_CAPABLE) && hif.tx_sel[tgt[2:0]]);
        any_hit = 1'b1;
        first_idx = tgt;
        first_fifo = (bp == `CRB_BP_FIFO);
        if (avail) begin
          any_avail = 1'b1;
          avail_idx = tgt;
          avail_fifo = (bp == `CRB_BP_FIFO);
        end
      end
    end
    next_s.valid = any_hit;
    next_s.store = any_avail;
    next_s.fifo = any_avail ? avail_fifo : first_fifo;
    next_s.index = any_avail ? avail_idx : first_idx;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hif.sel = s;

endmodule

`default_nettype wire

// >>> dv/crb_rx_asserts.sv
// Port checker of the receive buffer manager.
`timescale 1ns/1ps
`default_nettype none
module crb_rx_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] filter_hit,
  input wire logic [63:0] filter_buffer_pointer,
  input wire logic [7:0] tx_rx_select_bit,
  input wire logic dma_req,
  input wire logic [4:0] dma_buffer_index,
  input wire logic rx_buffer_irq_flag,
  input wire logic rx_overflow_irq_flag,
  input wire logic fifo_almost_full_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_hit;
    |filter_hit;
  endsequence
  sequence s_answer;
    dma_req ^ rx_overflow_irq_flag;
  endsequence
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_error_on_unmapped: assert property (pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00))
    else $error("wrong slave error");
  chk_hit_answered: assert property (s_hit |-> ##2 s_answer)
    else $error("hit not answered");
  chk_no_spurious_answer: assert property (s_answer |-> $past(|filter_hit, 2))
    else $error("answer without hit");
  chk_store_irq_pair: assert property (dma_req == rx_buffer_irq_flag)
    else $error("store and buffer irq differ");
  chk_store_single_pulse: assert property (dma_req |=> !dma_req)
    else $error("store pulse too long");
  chk_overflow_drops: assert property (rx_overflow_irq_flag |-> !dma_req)
    else $error("overflow with store");
  chk_almost_full_store: assert property (fifo_almost_full_irq |-> dma_req)
    else $error("almost full without store");
  chk_direct_index: assert property (filter_hit == 16'h0002 && filter_buffer_pointer[7:4] != 4'hf |-> ##2
    (rx_overflow_irq_flag || dma_buffer_index == {1'b0, $past(filter_buffer_pointer[7:4], 2)}))
    else $error("direct index wrong");
  chk_tx_buffer_refused: assert property (filter_hit == 16'h0010 && !filter_buffer_pointer[19] &&
    tx_rx_select_bit[filter_buffer_pointer[18:16]] |-> ##2 rx_overflow_irq_flag)
    else $error("transmit buffer stored");
endmodule
bind crb_rx_buffer_manager crb_rx_asserts i_chk (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .filter_hit(filter_hit),
  .filter_buffer_pointer(filter_buffer_pointer), .tx_rx_select_bit(tx_rx_select_bit), .dma_req(dma_req),
  .dma_buffer_index(dma_buffer_index), .rx_buffer_irq_flag(rx_buffer_irq_flag),
  .rx_overflow_irq_flag(rx_overflow_irq_flag), .fifo_almost_full_irq(fifo_almost_full_irq));
`default_nettype wire

// >>> dv/crb_filter_model.sv
// Acceptance filter side model that presents the hits of one message.
`timescale 1ns/1ps
`default_nettype none
module crb_filter_model (
  input wire logic mclk,
  output logic [15:0] filter_hit
);
  initial filter_hit = 16'h0000;
  // All hits of a message come together as one pulse; the extra edge keeps hits apart.
  task automatic send(input logic [15:0] m);
    @(posedge mclk);
    filter_hit <= m;
    @(posedge mclk);
    filter_hit <= 16'h0000;
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench of the receive buffer manager.
`timescale 1ns/1ps
`default_nettype none
`include "crb_consts.svh"
module testbench;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, m_full = 0, m_ovf = 0;
  logic pready, pslverr, dma_req, rb, ovf, af;
  logic [15:0] filter_hit;
  logic [63:0] bp = 0;
  logic [7:0] tx = 8'h04;
  logic [4:0] idx;
  logic [5:0] m_wp = 0, m_nr = 0, m_st = 0, m_end = 3;
  int miscompares = 0, total_checks = 0;
  int cnt[8] = '{4, 6, 8, 12, 16, 24, 32, 32};
  always #2.5 mclk = ~mclk;
  crb_filter_model i_filt (.mclk(mclk), .filter_hit(filter_hit));
  crb_rx_buffer_manager i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .filter_hit(filter_hit),
    .filter_buffer_pointer(bp), .tx_rx_select_bit(tx), .dma_req(dma_req), .dma_buffer_index(idx),
    .rx_buffer_irq_flag(rb), .rx_overflow_irq_flag(ovf), .fifo_almost_full_irq(af));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e, "read");
  endtask
  // Keeps the expected flags and pointers in step with writes to fifo_control and to the full-flag words.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
    if (a == `CRB_OFF_FCTRL) begin
      m_st = {1'b0, d[4:0]};
      m_end = 6'(cnt[d[15:13]] - 1);
      m_wp = m_st;
      m_nr = m_st;
    end
    for (int i = 0; i < 16; i++) begin
      if ((a == `CRB_OFF_FULL_LO || a == `CRB_OFF_FULL_HI) && !d[i] && m_full[i + 16 * a[2]]) begin
        m_full[i + 16 * a[2]] = 0;
        m_nr = 6'(i + 16 * a[2] + 1);
      end
    end
  endtask
  // The lowest filter with a free target stores; with none free the lowest filter's target overflows.
  task automatic hit(input logic [15:0] m);
    int s, t;
    logic f, a, sf;
    s = -1;
    f = 0;
    sf = 0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        f = bp[4 * i +: 4] == 4'hf;
        t = f ? int'(m_wp) : int'(bp[4 * i +: 4]);
        if (!m_full[t] && !(t < 8 && tx[t])) begin
          s = t;
          sf = f;
        end
      end
    end
    a = 0;
    if (s >= 0) m_full[s] = 1;
    else m_ovf[t] = 1;
    // The pointer moves only when the chosen target is the FIFO one.
    if (s >= 0 ? sf : f) m_wp = m_wp >= m_end ? m_st : m_wp + 6'd1;
    if (s >= 0 && sf) a = (m_nr - m_wp == 6'd1) || (m_nr == m_st && m_wp == m_end);
    i_filt.send(m);
    @(posedge mclk);
    #1;
    chk({dma_req, rb, ovf, af}, {s >= 0, s >= 0, s < 0, a}, "hit");
    if (s >= 0) chk(idx, s, "index");
  endtask
  initial begin
    void'($urandom(6835));
    for (int i = 5; i < 16; i++) bp[4 * i +: 4] <= 4'($urandom % 15);
    bp[19:0] <= 20'h2433f;
    repeat (8) @(posedge mclk);
    reset <= 0;
    rdc(`CRB_OFF_FCTRL, 0);
    rdc(`CRB_OFF_FPTR, 0);
    apb(0, 12'h018, 0);
    chk(err, 1, "unmapped");
    wr(`CRB_OFF_FPTR, 32'hffff);
    rdc(`CRB_OFF_FPTR, 0);
    // FIFO 5-11 holds no transmit buffer
    wr(`CRB_OFF_FCTRL, 32'h6005);
    rdc(`CRB_OFF_FCTRL, 32'h6005);
    rdc(`CRB_OFF_FPTR, 32'h0505);
    repeat (6) hit(16'h0001);
    rdc(`CRB_OFF_FULL_LO, m_full[15:0]);
    wr(`CRB_OFF_FULL_LO, 32'hffdf);
    rdc(`CRB_OFF_FPTR, 32'h0b06);
    repeat (3) hit(16'h0001);
    $display("test fifo done");
    hit(16'h0002);
    hit(16'h0006);
    hit(16'h000e);
    hit(16'h0010);
    rdc(`CRB_OFF_OVF_LO, m_ovf[15:0]);
    $display("test direct done");
    for (int n = 0; n < 30; n++) begin
      wr(`CRB_OFF_FULL_LO, $urandom);
      tx <= 8'($urandom);
      @(posedge mclk);
      hit(16'($urandom) & 16'hfffe | 16'h8000);
    end
    rdc(`CRB_OFF_FULL_LO, m_full[15:0]);
    rdc(`CRB_OFF_OVF_LO, m_ovf[15:0]);
    $display("test random done");
    tx <= 8'h01;
    wr(`CRB_OFF_FULL_LO, 0);
    wr(`CRB_OFF_FCTRL, 0);
    repeat (5) hit(16'h0001);
    for (int c = 0; c < 8; c++) begin
      wr(`CRB_OFF_FCTRL, {16'h0, 3'(c), 13'h001e});
      rdc(`CRB_OFF_FCTRL, {16'h0, 3'(c), 13'h001e});
    end
    repeat (3) hit(16'h0001);
    rdc(`CRB_OFF_FULL_HI, m_full[31:16]);
    rdc(`CRB_OFF_OVF_HI, m_ovf[31:16]);
    $display("test wrap done");
    results();
  end
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
